// ---- ifb_pkg.sv ----
/*
  constants, types and channel structs for the instruction fetch buffer unit.
  assumes one processor clock (aclk, 100 MHz) and a sync active-low reset.
*/
// Function
// RQ1 - eight buffers, each of 32 words, each word four 16-bit parcels
// RQ2 - each buffer covers an aligned 32-word block named by the upper 17 bits
// RQ3 - each buffer has a tag holding the upper 17 bits and a valid bit
// RQ4 - a context exchange clears every tag valid bit
// RQ5 - fetch start writes the chosen tag from the address and sets valid
// RQ6 - program address is 24 bits: 22-bit word address, 2-bit parcel select
// RQ7 - address advances by 1 for one- or two-parcel, by 2 for three-parcel
// RQ8 - a taken branch loads any address instead of the increment
// RQ9 - saved address on exchange points after the last executed instruction
// RQ10 - every cycle compare upper 17 bits with all eight tags; valid match hits
// RQ11 - no valid matching tag means a miss and a fetch sequence starts
// RQ12 - a fetch reads 32 consecutive words over the instruction port, one per cycle
// RQ13 - buffers are refilled in circular order, first through eighth, then first again
// RQ14 - the first word fetched is the word holding the addressed parcel
// RQ15 - an address held in a valid buffer is never fetched again
// RQ16 - buffers do not watch memory writes; resident words stay stale
// RQ17 - unhindered: first word after 36 cycles, current parcel 3 later, full in 67
// RQ18 - issue proceeds during a fetch whenever the needed parcel is present
// RQ19 - a hit moves the parcel to the next-parcel then current-parcel register
// RQ20 - even and odd read-out registers; bit 0 picks one, bits -1/-2 the parcel
// RQ21 - word address bits 4..0 index the word inside the buffer
// RQ22 - fetch writes ascending from the needed word, wrapping; only written words hit
package ifb_pkg;
  localparam int NBUF = 8;
  localparam int NWORD = 32;
  localparam int PADDR_W = 24;
  localparam int TAG_W = 17;
  localparam int IDX_W = 5;
  localparam int WADDR_W = 22;
  localparam int PARCEL_W = 16;
  localparam int WORD_W = 64;
  // unhindered fetch timing, in clock periods
  localparam int CYC_FIRST_WORD = 36;
  localparam int CYC_TO_CURRENT = 3;
  localparam int CYC_FILL = 67;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PADDR = 8'h08;
  localparam logic [7:0] REG_FETCHES = 8'h0c;
  // ctrl fields
  localparam int CTRL_FETCH_EN = 0;
  localparam int CTRL_INVAL = 1;
  localparam int CTRL_CLR_SLOW = 2;
  localparam logic CTRL_FETCH_EN_RST = 1'b1;
  // status fields
  localparam int ST_HIT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PTR_LO = 2;
  localparam int ST_SLOW = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [PADDR_W-1:0] PADDR_RST = 24'h000000;

  typedef logic [PADDR_W-1:0] ifb_paddr_t;
  typedef struct packed {
    logic [WADDR_W-1:0] waddr;
  } ifb_mreq_s;
  typedef struct packed {
    logic [WORD_W-1:0] data;
  } ifb_mrsp_s;
  typedef enum logic {IFB_IDLE, IFB_FETCH} ifb_fsm_e;
endpackage : ifb_pkg

// ---- ifb_fetch_unit.sv ----
/*
  instruction fetch buffer unit: program address, eight tagged 32-word buffers,
  circular refill over the instruction memory port, even/odd read-out, next and
  current parcel registers, and an axi4-lite register slave.
  assumes memory answers word requests in order on mem_rsp_valid.
*/
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module ifb_fetch_unit (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // issue side
  input wire logic adv_one,
  input wire logic adv_two,
  input wire logic branch_valid,
  input wire ifb_pkg::ifb_paddr_t branch_paddr,
  input wire logic exchange,
  input wire ifb_pkg::ifb_paddr_t exchange_paddr,
  input wire logic issue_hold,
  output ifb_pkg::ifb_paddr_t paddr,
  output ifb_pkg::ifb_paddr_t saved_paddr,
  output logic in_buffer,
  output logic fetch_busy,
  output logic [15:0] next_parcel,
  output logic next_parcel_vld,
  output logic [15:0] current_parcel,
  output logic current_parcel_vld,
  // instruction memory port
  output logic mem_req_valid,
  output ifb_pkg::ifb_mreq_s mem_req,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire ifb_pkg::ifb_mrsp_s mem_rsp
);
  import ifb_pkg::*;
  // program address and buffer state
  ifb_paddr_t p_ff, nxt_p;
  logic [TAG_W-1:0] tag_ff [NBUF];
  logic [NBUF-1:0] tag_vld_ff;
  logic [NWORD-1:0] written_ff [NBUF];
  logic [WORD_W-1:0] buf_mem [NBUF*NWORD];
  logic [2:0] fill_ptr_ff;
  logic [2:0] fbuf_ff;
  logic [IDX_W-1:0] req_cnt_ff, rsp_cnt_ff, start_idx_ff;
  logic req_done_ff;
  ifb_fsm_e state_ff;
  logic [6:0] fcyc_ff;
  logic slow_ff, wr_inval, wr_clr_slow;
  logic fetch_en_ff;
  logic [31:0] fetches_ff;
  // address fields
  wire [TAG_W-1:0] p_tag = p_ff[PADDR_W-1 -: TAG_W]; // RQ2
  wire [IDX_W-1:0] p_idx = p_ff[2 +: IDX_W]; // RQ21
  wire [IDX_W-2:0] p_pair = p_ff[3 +: IDX_W-1];
  // per-buffer tag compare
  logic [NBUF-1:0] tag_match;
  logic [NBUF-1:0] word_hit;
  genvar g;
  generate
    for (g = 0; g < NBUF; g++) begin : g_cmp
      assign tag_match[g] = tag_vld_ff[g] && (tag_ff[g] == p_tag); // RQ10
      assign word_hit[g] = tag_match[g] && written_ff[g][p_idx]; // RQ22
    end
  endgenerate
  // hit buffer encode
  logic [2:0] hit_buf;
  always_comb begin
    hit_buf = 3'h0;
    for (int i = 0; i < NBUF; i++) begin
      if (word_hit[i]) begin
        hit_buf = i[2:0];
      end
    end
  end
  // miss detection and fetch start
  wire any_match = |tag_match;
  wire hit = |word_hit; // RQ10
  wire inval = exchange || wr_inval; // RQ4
  wire start_fetch = (state_ff == IFB_IDLE) && !any_match && fetch_en_ff; // RQ11 RQ15
  wire rsp_take = (state_ff == IFB_FETCH) && mem_rsp_valid;
  wire req_take = mem_req_valid && mem_req_ready;
  wire fetch_last = rsp_take && (rsp_cnt_ff == 5'h1f);
  wire [IDX_W-1:0] req_idx = start_idx_ff + req_cnt_ff; // RQ22
  wire [IDX_W-1:0] rsp_idx = start_idx_ff + rsp_cnt_ff;
  wire [7:0] wr_slot = {fbuf_ff, rsp_idx};
  assign mem_req_valid = (state_ff == IFB_FETCH) && !req_done_ff; // RQ12
  assign mem_req.waddr = {tag_ff[fbuf_ff], req_idx}; // RQ14
  assign in_buffer = hit;
  assign fetch_busy = (state_ff == IFB_FETCH);
  assign paddr = p_ff;
  assign saved_paddr = p_ff; // RQ9
  // next program address
  always_comb begin
    nxt_p = p_ff;
    if (exchange) begin
      nxt_p = exchange_paddr;
    end else if (branch_valid) begin
      nxt_p = branch_paddr; // RQ8
    end else if (adv_two) begin
      nxt_p = p_ff + 24'h000002; // RQ7
    end else if (adv_one) begin
      nxt_p = p_ff + 24'h000001; // RQ7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_ff <= PADDR_RST; // RQ6
    end else begin
      p_ff <= nxt_p;
    end
  end
  // tags: set on fetch start, valid cleared on exchange
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_vld_ff <= '0;
      fill_ptr_ff <= 3'h0;
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (inval) begin
          tag_vld_ff[i] <= 1'b0; // RQ4
        end else if (start_fetch && fill_ptr_ff == i[2:0]) begin
          tag_vld_ff[i] <= 1'b1; // RQ5
        end
      end
      if (start_fetch) begin
        fill_ptr_ff <= fill_ptr_ff + 3'h1; // RQ13
      end
    end
  end
  // tag values need no reset, validity guards them
  always_ff @(posedge aclk) begin
    if (start_fetch) begin
      tag_ff[fill_ptr_ff] <= p_tag; // RQ3 RQ5
    end
  end
  // word-written marks, cleared when a buffer is reloaded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      written_ff <= '{default: '0};
    end else begin
      if (start_fetch) begin
        written_ff[fill_ptr_ff] <= '0;
      end else if (rsp_take) begin
        written_ff[fbuf_ff][rsp_idx] <= 1'b1; // RQ22
      end
    end
  end
  // buffer storage, one word per cycle; no snooping of memory writes
  always_ff @(posedge aclk) begin
    if (rsp_take) begin
      buf_mem[wr_slot] <= mem_rsp.data; // RQ1 RQ12 RQ16
    end
  end
  // fetch sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= IFB_IDLE;
      fbuf_ff <= 3'h0;
      start_idx_ff <= '0;
      req_cnt_ff <= '0;
      rsp_cnt_ff <= '0;
      req_done_ff <= 1'b0;
    end else begin
      case (state_ff)
        IFB_IDLE: begin
          if (start_fetch) begin
            state_ff <= IFB_FETCH;
            fbuf_ff <= fill_ptr_ff; // RQ13
            start_idx_ff <= p_idx; // RQ14
            req_cnt_ff <= '0;
            rsp_cnt_ff <= '0;
            req_done_ff <= 1'b0;
          end
        end
        IFB_FETCH: begin
          if (req_take) begin
            req_cnt_ff <= req_cnt_ff + 5'h01;
            if (req_cnt_ff == 5'h1f) begin
              req_done_ff <= 1'b1;
            end
          end
          if (rsp_take) begin
            rsp_cnt_ff <= rsp_cnt_ff + 5'h01;
          end
          if (fetch_last) begin
            state_ff <= IFB_IDLE;
          end
        end
        default: begin
          state_ff <= IFB_IDLE;
        end
      endcase
    end
  end
  // fetch length watch: flags fetches that memory conflicts stretched
  wire late_first = (fcyc_ff >= 7'(CYC_FIRST_WORD)) && (rsp_cnt_ff == 5'h00) && !rsp_take;
  wire late_fill = fetch_last && (fcyc_ff >= 7'(CYC_FILL)); // RQ17
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcyc_ff <= '0;
      slow_ff <= 1'b0;
      fetches_ff <= '0;
    end else begin
      if (start_fetch) begin
        fcyc_ff <= 7'h01;
        fetches_ff <= fetches_ff + 32'h00000001;
      end else if (fetch_busy && fcyc_ff != 7'h7f) begin
        fcyc_ff <= fcyc_ff + 7'h01;
      end
      if ((fetch_busy && late_first) || late_fill) begin
        slow_ff <= 1'b1; // set wins over clear
      end else if (wr_clr_slow) begin
        slow_ff <= 1'b0;
      end
    end
  end
  // even and odd read-out registers, fed while fetch runs
  logic [WORD_W-1:0] ro_even_ff, ro_odd_ff;
  logic ro_vld_ff;
  logic [2:0] ro_sel_ff;
  wire [7:0] even_slot = {hit_buf, p_pair, 1'b0};
  wire [7:0] odd_slot = {hit_buf, p_pair, 1'b1};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ro_vld_ff <= 1'b0;
      ro_sel_ff <= 3'h0;
      ro_even_ff <= '0;
      ro_odd_ff <= '0;
    end else begin
      ro_vld_ff <= hit && !inval; // RQ18
      ro_sel_ff <= p_ff[2:0];
      ro_even_ff <= buf_mem[even_slot]; // RQ20
      ro_odd_ff <= buf_mem[odd_slot]; // RQ20
    end
  end
  // parcel select: bit 0 picks read-out register, bits -1/-2 the parcel
  wire [WORD_W-1:0] ro_word = ro_sel_ff[2] ? ro_odd_ff : ro_even_ff; // RQ20
  wire [PARCEL_W-1:0] ro_parcel = ro_word[(3 - ro_sel_ff[1:0]) * PARCEL_W +: PARCEL_W];
  // next-parcel and current-parcel stages, CYC_TO_CURRENT cycles from buffer
  logic [PARCEL_W-1:0] next_ff, cur_ff;
  logic next_vld_ff, cur_vld_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_ff <= '0;
      next_vld_ff <= 1'b0;
      cur_ff <= '0;
      cur_vld_ff <= 1'b0;
    end else if (!issue_hold) begin
      next_ff <= ro_parcel; // RQ19
      next_vld_ff <= ro_vld_ff && !exchange;
      cur_ff <= next_ff; // RQ19
      cur_vld_ff <= next_vld_ff && !exchange;
    end
  end
  assign next_parcel = next_ff;
  assign next_parcel_vld = next_vld_ff;
  assign current_parcel = cur_ff;
  assign current_parcel_vld = cur_vld_ff;
  // axi4-lite write channel: address and data latched in either order
  logic aw_have_ff, w_have_ff, bvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire wr_commit = aw_have_ff && w_have_ff && !bvalid_ff;
  wire wr_ctrl = wr_commit && (awaddr_ff[7:2] == REG_CTRL[7:2]) && wstrb_ff[0];
  wire wr_mapped = (awaddr_ff[7:2] == REG_CTRL[7:2]);
  assign wr_inval = wr_ctrl && wdata_ff[CTRL_INVAL];
  assign wr_clr_slow = wr_ctrl && wdata_ff[CTRL_CLR_SLOW];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      fetch_en_ff <= CTRL_FETCH_EN_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_commit) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        fetch_en_ff <= wdata_ff[CTRL_FETCH_EN];
      end
    end
  end
  // axi4-lite read channel, answer one cycle after address
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_val;
  logic rd_ok;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr[7:2])
      REG_CTRL[7:2]: rd_val[CTRL_FETCH_EN] = fetch_en_ff;
      REG_STATUS[7:2]: begin
        rd_val[ST_HIT] = hit;
        rd_val[ST_BUSY] = fetch_busy;
        rd_val[ST_PTR_LO +: 3] = fill_ptr_ff;
        rd_val[ST_SLOW] = slow_ff;
      end
      REG_PADDR[7:2]: rd_val[PADDR_W-1:0] = p_ff;
      REG_FETCHES[7:2]: rd_val = fetches_ff;
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : ifb_fetch_unit

// ---- ifb_mem_model.sv ----
/*
  behavioural instruction memory behind the fetch port: in-order word reads.
  assumes one clock and a sync active-low reset; slow stalls request acceptance.
*/
`timescale 1ns/1ps
module ifb_mem_model
  import ifb_pkg::*;
#(
  parameter int LAT = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic mem_req_valid,
  input wire ifb_pkg::ifb_mreq_s mem_req,
  output logic mem_req_ready,
  output logic mem_rsp_valid,
  output ifb_pkg::ifb_mrsp_s mem_rsp
);
  int cyc = 0;
  logic [WADDR_W-1:0] q_addr[$];
  int q_due[$];
  logic [13:0] w;

  // every other cycle only when stalling
  assign mem_req_ready = !slow || cyc[0];

  // queue requests, answer in order after the latency, one word a cycle
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!aresetn) begin
      q_addr.delete();
      q_due.delete();
      mem_rsp_valid <= 1'h0;
      mem_rsp.data <= 64'h0;
    end else begin
      if (mem_req_valid && mem_req_ready) begin
        q_addr.push_back(mem_req.waddr);
        q_due.push_back(cyc + LAT);
      end
      if (q_due.size() > 0 && q_due[0] <= cyc) begin
        w = 14'(q_addr.pop_front());
        void'(q_due.pop_front());
        mem_rsp_valid <= 1'h1;
        mem_rsp.data <= {w, 2'h0, w, 2'h1, w, 2'h2, w, 2'h3};
      end else begin
        mem_rsp_valid <= 1'h0;
        mem_rsp.data <= ~mem_rsp.data; // idle data inverted each cycle, so the last word shows every other idle cycle
      end
    end
  end
endmodule : ifb_mem_model

// ---- ifb_fetch_unit_properties.sv ----
/*
  concurrent checks on the fetch unit ports.
  bound into ifb_fetch_unit by the bench; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module ifb_fetch_unit_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic adv_one,
  input wire logic adv_two,
  input wire logic branch_valid,
  input wire ifb_pkg::ifb_paddr_t branch_paddr,
  input wire logic exchange,
  input wire logic issue_hold,
  input wire ifb_pkg::ifb_paddr_t paddr,
  input wire ifb_pkg::ifb_paddr_t saved_paddr,
  input wire logic in_buffer,
  input wire logic fetch_busy,
  input wire logic [15:0] next_parcel,
  input wire logic next_parcel_vld,
  input wire logic [15:0] current_parcel,
  input wire logic mem_req_valid,
  input wire ifb_pkg::ifb_mreq_s mem_req,
  input wire logic mem_req_ready
);
  import ifb_pkg::*;
  logic [5:0] req_cnt_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // requests taken since the fetch began
  always_ff @(posedge aclk) begin
    if (!aresetn || !fetch_busy) begin
      req_cnt_ff <= 6'h00;
    end else if (mem_req_valid && mem_req_ready) begin
      req_cnt_ff <= req_cnt_ff + 6'h01;
    end
  end

  // idle unit facing a word that is not resident
  sequence s_idle_miss;
    !fetch_busy && !in_buffer && !exchange;
  endsequence
  // plain sequential step of one or two
  sequence s_step;
    (adv_one ^ adv_two) && !branch_valid && !exchange;
  endsequence

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without read data next cycle");
  a_exch_clear: assert property (exchange |=> !in_buffer)
    else $error("hit right after a context exchange");
  a_step_add: assert property (s_step |=>
    paddr == $past(paddr) + ($past(adv_two) ? 24'h000002 : 24'h000001))
    else $error("program address step wrong");
  a_branch_load: assert property (branch_valid && !exchange |=> paddr == $past(branch_paddr))
    else $error("branch address not loaded");
  a_saved_addr: assert property (saved_paddr == paddr)
    else $error("saved address differs from program address");
  a_miss_fetch: assert property (s_idle_miss |=> fetch_busy)
    else $error("miss while idle did not start a fetch");
  a_req_busy: assert property (mem_req_valid |-> fetch_busy)
    else $error("memory request outside a fetch");
  a_fetch_len: assert property ($fell(fetch_busy) |-> req_cnt_ff == 6'h20)
    else $error("fetch did not take exactly 32 requests");
  a_first_word: assert property ($rose(fetch_busy) && $stable(paddr) |->
    ##[0:2] (mem_req_valid && mem_req.waddr == paddr[23:2]))
    else $error("first request is not the addressed word");
  a_parcel_move: assert property (next_parcel_vld && !issue_hold && !exchange |=>
    current_parcel == $past(next_parcel))
    else $error("next parcel did not move to current parcel");
endmodule : ifb_fetch_unit_properties

// ---- tb_instruction_fetch_buffer_unit.sv ----
/*
  self-checking bench: fetch unit, behavioural memory, axi4-lite master tasks.
  assumes a 100 MHz clock and 16 cycles of reset; the checker is bound below.
*/
`timescale 1ns/1ps
module tb_instruction_fetch_buffer_unit;
  import ifb_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, cnt;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic adv_one = 1'h0, adv_two = 1'h0, branch_valid = 1'h0, exchange = 1'h0;
  logic issue_hold = 1'h0, mem_slow = 1'h0;
  ifb_paddr_t branch_paddr = 24'h0, exchange_paddr = 24'h0, paddr, saved_paddr;
  logic in_buffer, fetch_busy, next_parcel_vld, current_parcel_vld;
  logic [15:0] next_parcel, current_parcel;
  logic mem_req_valid, mem_req_ready, mem_rsp_valid;
  ifb_mreq_s mem_req;
  ifb_mrsp_s mem_rsp;
  int num_errors = 0, n_compared = 0, cyc = 0;

  ifb_fetch_unit i_ifb_fetch_unit (.*);
  ifb_mem_model i_ifb_mem_model (
    .aclk(aclk), .aresetn(aresetn), .slow(mem_slow), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp(mem_rsp)
  );

  // clock
  always #5 aclk = ~aclk;

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    b_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
      b_ok = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    ar_ok = 1'h0;
    r_ok = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = ar_ok || s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  // branch to a, wait for the hit, follow the parcel down the issue path
  task automatic look(input ifb_paddr_t a);
    @(posedge aclk);
    branch_valid <= 1'h1;
    branch_paddr <= a;
    @(posedge aclk);
    branch_valid <= 1'h0;
    @(negedge aclk);
    while (in_buffer !== 1'h1) @(negedge aclk);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({16'h0, next_parcel}, {16'h0, a[15:0]});
    @(negedge aclk);
    chk({16'h0, current_parcel}, {16'h0, a[15:0]});
    chk({31'h0, current_parcel_vld}, 32'h1);
  endtask : look

  task automatic settle();
    @(negedge aclk);
    while (fetch_busy !== 1'h0) @(negedge aclk);
  endtask : settle

  task automatic t_regs();
    axi_rd(REG_CTRL, rd, rsp);
    chk(rd & 32'h1, 32'h1);
    axi_rd(8'h10, rd, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h20, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask : t_regs

  // every parcel select, even and odd words, while the first fetch streams in
  task automatic t_cold();
    for (int i = 0; i < 8; i++) look(24'(i * 3));
    settle();
  endtask : t_cold

  task automatic t_circ();
    for (int k = 1; k <= 8; k++) begin
      look({k[16:0], 5'(k + 3), 2'(k)});
      settle();
      axi_rd(REG_STATUS, rd, rsp);
      chk({29'h0, rd[4:2]}, 32'((k + 2) % 8));
    end
    axi_rd(REG_FETCHES, cnt, rsp);
    look(24'h000081);
    axi_rd(REG_FETCHES, rd, rsp);
    chk(rd, cnt);
    look(24'h000002);
    settle();
    axi_rd(REG_FETCHES, rd, rsp);
    chk(rd, cnt + 32'h1);
  endtask : t_circ

  task automatic t_exch();
    axi_rd(REG_FETCHES, cnt, rsp);
    exchange <= 1'h1;
    exchange_paddr <= 24'h000106;
    @(posedge aclk);
    exchange <= 1'h0;
    look(24'h000106);
    settle();
    look(24'h000107);
    axi_rd(REG_FETCHES, rd, rsp);
    chk(rd, cnt + 32'h1);
  endtask : t_exch

  task automatic t_step();
    ifb_paddr_t p;
    @(negedge aclk);
    p = paddr;
    @(posedge aclk);
    adv_one <= 1'h1;
    @(posedge aclk);
    adv_one <= 1'h0;
    adv_two <= 1'h1;
    @(negedge aclk);
    chk({8'h0, paddr}, {8'h0, p + 24'h000001});
    @(posedge aclk);
    adv_two <= 1'h0;
    adv_one <= 1'h1;
    branch_valid <= 1'h1;
    branch_paddr <= 24'h000140;
    @(negedge aclk);
    chk({8'h0, paddr}, {8'h0, p + 24'h000003});
    @(posedge aclk);
    adv_one <= 1'h0;
    branch_valid <= 1'h0;
    @(negedge aclk);
    chk({8'h0, paddr}, 32'h140);
    chk({8'h0, saved_paddr}, 32'h140);
    axi_rd(REG_PADDR, rd, rsp);
    chk(rd, 32'h140);
    // hold the issue stages across a branch, then let them move on
    @(posedge aclk);
    issue_hold <= 1'h1;
    branch_valid <= 1'h1;
    branch_paddr <= 24'h000141;
    @(posedge aclk);
    branch_valid <= 1'h0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk({16'h0, current_parcel}, 32'h140);
    @(posedge aclk);
    issue_hold <= 1'h0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({16'h0, current_parcel}, 32'h141);
  endtask : t_step

  task automatic t_slow();
    axi_rd(REG_STATUS, rd, rsp);
    chk({31'h0, rd[ST_SLOW]}, 32'h0);
    mem_slow <= 1'h1;
    look(24'h000c00);
    settle();
    axi_rd(REG_STATUS, rd, rsp);
    chk({31'h0, rd[ST_SLOW]}, 32'h1);
    mem_slow <= 1'h0;
    axi_wr(REG_CTRL, 32'h5, rsp);
    axi_rd(REG_STATUS, rd, rsp);
    chk({31'h0, rd[ST_SLOW]}, 32'h0);
  endtask : t_slow

  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_cold();
    t_slow();
    t_circ();
    t_exch();
    t_step();
    wrap_up();
  end
endmodule : tb_instruction_fetch_buffer_unit

bind ifb_fetch_unit ifb_fetch_unit_properties i_ifb_fetch_unit_properties (.*);
